// ==== pfa_formatter.v ====
`timescale 1ns/1ns
`include "pfa_defs.vh"
module pfa_formatter (
  input wire clock_in,
  input wire resetn_in,
  input wire write_start_in,
  input wire read_start_in,
  input wire [31:0] post_data_in,
  input wire use_lock_in,
  input wire sector_in,
  input wire ref_read_clk_in,
  input wire read_data_in,
  output reg write_gate_out,
  output reg read_gate_out,
  output reg write_clk_out,
  output reg write_data_out,
  output reg busy_out,
  output reg done_out,
  output reg [31:0] post_data_out,
  output reg check_ok_out,
  output reg check_err_out,
  output reg pattern_miss_out,
  output reg maker_pattern_out
);
  localparam ST_IDLE = 4'h0;
  localparam ST_WAIT = 4'h1;
  localparam ST_SPLICE = 4'h2;
  localparam ST_LOCK = 4'h3;
  localparam ST_PAT = 4'h4;
  localparam ST_POST = 4'h5;
  localparam ST_CHECK = 4'h6;
  localparam ST_PAD = 4'h7;
  localparam ST_RWAIT = 4'h8;
  localparam ST_HUNT = 4'h9;
  localparam ST_RPOST = 4'hA;
  localparam ST_RCHECK = 4'hB;

  wire rclk_level;
  wire rclk_rise;
  wire sector_rise;
  wire [15:0] crc;
  reg rdata_meta;
  reg rdata_sync;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [2:0] bit_cnt;
  reg [3:0] byte_cnt;
  reg [5:0] splice_cnt;
  reg [11:0] search_cnt;
  reg [31:0] shreg;
  reg [15:0] hunt;
  reg [15:0] rx_check;
  reg use_lock;
  reg crc_init;
  reg crc_shift;
  reg crc_bit;
  reg next_bit;

  pfa_edge_sync u_rclk (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .async_in(ref_read_clk_in),
    .level_out(rclk_level),
    .rise_out(rclk_rise)
  );

  pfa_edge_sync u_sector (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .async_in(sector_in),
    .level_out(),
    .rise_out(sector_rise)
  );

  pfa_crc16 u_crc (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .init_in(crc_init),
    .shift_in(crc_shift),
    .bit_in(crc_bit),
    .crc_out(crc)
  );

  // Read data sampled through two stages, like the sector and reference clock pins
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_meta <= 1'b0;
      rdata_sync <= 1'b0;
    end else begin
      rdata_meta <= read_data_in;
      rdata_sync <= rdata_meta;
    end
  end

  wire last_bit;
  assign last_bit = rclk_rise && (bit_cnt == 3'h7);
  wire [7:0] pat_byte;
  assign pat_byte = (byte_cnt == 4'h0) ? `PFA_PAT0 : `PFA_PAT1;

  // Serial bit presented in the current bit time
  always @* begin
    case (state)
      ST_POST: next_bit = shreg[31];
      ST_CHECK: next_bit = shreg[31];
      ST_PAT: next_bit = pat_byte[3'h7 - bit_cnt];
      default: next_bit = 1'b0;
    endcase
  end

  always @* begin
    crc_init = (state == ST_IDLE) || (state == ST_HUNT);
    crc_shift = 1'b0;
    crc_bit = 1'b0;
    if (rclk_rise && (state == ST_POST)) begin
      crc_shift = 1'b1;
      crc_bit = shreg[31];
    end else if (rclk_rise && (state == ST_RPOST)) begin
      crc_shift = 1'b1;
      crc_bit = rdata_sync;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (write_start_in) begin
          next_state = ST_WAIT;
        end else if (read_start_in) begin
          next_state = ST_RWAIT;
        end
      end
      ST_WAIT: begin
        if (sector_rise) begin
          next_state = ST_SPLICE;
        end
      end
      ST_SPLICE: begin
        if (rclk_rise && (splice_cnt == 6'h01)) begin
          next_state = use_lock ? ST_LOCK : ST_PAT;
        end
      end
      ST_LOCK: begin
        if (last_bit && (byte_cnt == `PFA_LOCK_BYTES - 4'h1)) begin
          next_state = ST_PAT;
        end
      end
      ST_PAT: begin
        if (last_bit && (byte_cnt == {2'h0, `PFA_PAT_BYTES} - 4'h1)) begin
          next_state = ST_POST;
        end
      end
      ST_POST: begin
        if (last_bit && (byte_cnt == `PFA_POST_BYTES - 4'h1)) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (last_bit && (byte_cnt == {2'h0, `PFA_CHECK_BYTES} - 4'h1)) begin
          next_state = ST_PAD;
        end
      end
      ST_PAD: begin
        // Gate drops one bit time after the last pad bit so the drive records all of it
        if (rclk_rise && (byte_cnt == {2'h0, `PFA_PAD_BYTES})) begin
          next_state = ST_IDLE;
        end
      end
      ST_RWAIT: begin
        if (sector_rise) begin
          next_state = ST_HUNT;
        end
      end
      ST_HUNT: begin
        if (rclk_rise) begin
          if ({hunt[14:0], rdata_sync} == {`PFA_PAT0, `PFA_PAT1} ||
              {hunt[14:0], rdata_sync} == {`PFA_MAKER_PAT0, `PFA_MAKER_PAT1}) begin
            next_state = ST_RPOST;
          end else if (search_cnt == 12'h001) begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_RPOST: begin
        if (last_bit && (byte_cnt == `PFA_POST_BYTES - 4'h1)) begin
          next_state = ST_RCHECK;
        end
      end
      ST_RCHECK: begin
        if (last_bit && (byte_cnt == {2'h0, `PFA_CHECK_BYTES} - 4'h1)) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // A fresh sector pulse mid-frame restarts field timing
    if (sector_rise && (state != ST_IDLE) && (state != ST_WAIT) && (state != ST_RWAIT)) begin
      next_state = (state >= ST_RWAIT) ? ST_HUNT : ST_SPLICE;
    end
  end

  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
      splice_cnt <= 6'h00;
      search_cnt <= 12'h000;
      shreg <= 32'h00000000;
      hunt <= 16'h0000;
      rx_check <= 16'h0000;
      use_lock <= 1'b0;
      write_gate_out <= 1'b0;
      read_gate_out <= 1'b0;
      write_clk_out <= 1'b0;
      write_data_out <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      post_data_out <= 32'h00000000;
      check_ok_out <= 1'b0;
      check_err_out <= 1'b0;
      pattern_miss_out <= 1'b0;
      maker_pattern_out <= 1'b0;
    end else begin
      state <= next_state;
      done_out <= 1'b0;
      check_ok_out <= 1'b0;
      check_err_out <= 1'b0;
      pattern_miss_out <= 1'b0;
      // Write clock follows the synchronised reference clock
      write_clk_out <= rclk_level;
      busy_out <= (next_state != ST_IDLE);
      write_gate_out <= (next_state >= ST_SPLICE) && (next_state <= ST_PAD);
      read_gate_out <= (next_state >= ST_HUNT);
      if (state == ST_IDLE) begin
        use_lock <= use_lock_in;
        shreg <= post_data_in;
      end
      // A sector pulse restarts the counters even when the state itself is kept
      if ((next_state != state) || sector_rise) begin
        bit_cnt <= 3'h0;
        byte_cnt <= 4'h0;
        splice_cnt <= `PFA_SPLICE_BITS;
        search_cnt <= `PFA_SEARCH_BITS;
      end else if (rclk_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          byte_cnt <= byte_cnt + 4'h1;
        end
        splice_cnt <= splice_cnt - 6'h01;
        search_cnt <= search_cnt - 12'h001;
        if (state == ST_RCHECK) begin
          rx_check <= {rx_check[14:0], rdata_sync};
        end
      end
      // Shifts also on the edge that leaves a field, so its last bit is kept
      if (rclk_rise && ((state == ST_POST) || (state == ST_CHECK) || (state == ST_RPOST))) begin
        shreg <= {shreg[30:0], (state == ST_RPOST) ? rdata_sync : 1'b0};
      end else if ((state == ST_CHECK) && (bit_cnt == 3'h0) && (byte_cnt == 4'h0)) begin
        // Loaded only once the last post bit has entered the CRC register
        shreg <= {crc, 16'h0000};
      end
      // Data changes only on reference rise, so it stays in step with write clock
      if (rclk_rise) begin
        write_data_out <= next_bit;
      end
      if (state == ST_IDLE) begin
        write_data_out <= 1'b0;
      end
      if (rclk_rise) begin
        hunt <= {hunt[14:0], rdata_sync};
      end
      if ((state == ST_HUNT) && (next_state == ST_RPOST)) begin
        maker_pattern_out <= ({hunt[14:0], rdata_sync} != {`PFA_PAT0, `PFA_PAT1});
      end
      if ((state == ST_HUNT) && (next_state == ST_IDLE)) begin
        pattern_miss_out <= 1'b1;
        done_out <= 1'b1;
      end
      if ((state == ST_PAD) && (next_state == ST_IDLE)) begin
        done_out <= 1'b1;
      end
      if ((state == ST_RCHECK) && (next_state == ST_IDLE)) begin
        done_out <= 1'b1;
        post_data_out <= shreg;
        // Compare received check with recomputed one
        if ({rx_check[14:0], rdata_sync} == crc) begin
          check_ok_out <= 1'b1;
        end else begin
          check_err_out <= 1'b1;
        end
      end
    end
  end
endmodule // pfa_formatter

// ==== pfa_defs.vh ====
`ifndef PFA_DEFS_VH
`define PFA_DEFS_VH
// Field lengths in bytes unless noted
`define PFA_SPLICE_BITS_MIN 8
`define PFA_SPLICE_BITS 6'h10
`define PFA_LOCK_BYTES 4'h4
`define PFA_PAT_BYTES 2'h2
`define PFA_POST_BYTES 4'h4
`define PFA_CHECK_BYTES 2'h2
`define PFA_PAD_BYTES 2'h2
// Own recording pattern and an alternate pattern written by the media maker
`define PFA_PAT0 8'hA1
`define PFA_PAT1 8'hFE
`define PFA_MAKER_PAT0 8'h4E
`define PFA_MAKER_PAT1 8'h1B
// CRC-16 polynomial for the check code
`define PFA_CRC_POLY 16'h1021
`define PFA_CRC_INIT 16'hFFFF
// Read search window in bits after the sector pulse
`define PFA_SEARCH_BITS 12'h400
`endif

// ==== pfa_edge_sync.v ====
`timescale 1ns/1ns
// Two-stage synchroniser with rise detection on the second stage
module pfa_edge_sync (
  input wire clock_in,
  input wire resetn_in,
  input wire async_in,
  output reg level_out,
  output reg rise_out
);
  reg meta;
  reg prev;
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta <= 1'b0;
      level_out <= 1'b0;
      prev <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      meta <= async_in;
      level_out <= meta;
      prev <= level_out;
      rise_out <= level_out & ~prev;
    end
  end
endmodule // pfa_edge_sync

// ==== pfa_crc16.v ====
`timescale 1ns/1ns
`include "pfa_defs.vh"
// Bit-serial CRC register, one bit per strobe
module pfa_crc16 (
  input wire clock_in,
  input wire resetn_in,
  input wire init_in,
  input wire shift_in,
  input wire bit_in,
  output reg [15:0] crc_out
);
  wire fb;
  assign fb = crc_out[15] ^ bit_in;
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      crc_out <= `PFA_CRC_INIT;
    end else if (init_in) begin
      crc_out <= `PFA_CRC_INIT;
    end else if (shift_in) begin
      crc_out <= {crc_out[14:0], 1'b0} ^ ({16{fb}} & `PFA_CRC_POLY);
    end
  end
endmodule // pfa_crc16

// ==== pfa_fmt_monitor.sv ====
`timescale 1ns/1ns
module pfa_fmt_monitor (
  input wire clock_in,
  input wire resetn_in,
  input wire write_start_in,
  input wire ref_read_clk_in,
  input wire write_gate_out,
  input wire read_gate_out,
  input wire write_clk_out,
  input wire write_data_out,
  input wire busy_out,
  input wire done_out,
  input wire check_ok_out,
  input wire check_err_out,
  input wire pattern_miss_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Saturates so a long write area cannot wrap back into the splice window
  reg [7:0] gate_age;
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) gate_age <= 8'h00;
    else if (!write_gate_out) gate_age <= 8'h00;
    else if (gate_age != 8'hFF) gate_age <= gate_age + 8'h01;
  end
  sequence s_wr_end;
    done_out && !read_gate_out;
  endsequence
  property p_splice; write_gate_out && gate_age < 8'h60 |-> !write_data_out; endproperty
  a_splice: assert property (p_splice) else $error("data high in splice");
  property p_pad; $fell(write_gate_out) |-> !$past(write_data_out, 2) && !$past(write_data_out, 150);
  endproperty
  a_pad: assert property (p_pad) else $error("pad not zero");
  property p_wend; $fell(write_gate_out) |-> ##[0:2] s_wr_end; endproperty
  a_wend: assert property (p_wend) else $error("no done after write");
  property p_wbusy; write_gate_out |-> busy_out; endproperty
  a_wbusy: assert property (p_wbusy) else $error("gate without busy");
  property p_take; write_start_in && !busy_out |=> busy_out; endproperty
  a_take: assert property (p_take) else $error("start not taken");
  property p_done; done_out |=> !done_out; endproperty
  a_done: assert property (p_done) else $error("done too long");
  property p_wclk; $rose(write_clk_out) |-> $past(ref_read_clk_in, 2); endproperty
  a_wclk: assert property (p_wclk) else $error("write clock off reference");
  property p_ok; check_ok_out || check_err_out |-> done_out && !(check_ok_out && check_err_out)
    ##1 !read_gate_out;
  endproperty
  a_ok: assert property (p_ok) else $error("bad check result");
  property p_miss; pattern_miss_out |-> done_out && !check_ok_out && !check_err_out; endproperty
  a_miss: assert property (p_miss) else $error("bad miss pulse");
endmodule // pfa_fmt_monitor
bind pfa_formatter pfa_fmt_monitor pfa_fmt_monitor_inst (.clock_in(clock_in),
  .resetn_in(resetn_in), .write_start_in(write_start_in), .ref_read_clk_in(ref_read_clk_in),
  .write_gate_out(write_gate_out), .read_gate_out(read_gate_out),
  .write_clk_out(write_clk_out), .write_data_out(write_data_out), .busy_out(busy_out),
  .done_out(done_out), .check_ok_out(check_ok_out), .check_err_out(check_err_out),
  .pattern_miss_out(pattern_miss_out));

// ==== pfa_drive_model.sv ====
`timescale 1ns/1ns
module pfa_drive_model (
  input wire read_gate_in,
  input wire write_gate_in,
  input wire write_data_in,
  output reg ref_read_clk_out,
  output reg sector_out,
  output reg read_data_out
);
  reg [95:0] rd_vec;
  integer rd_len;
  integer rd_idx;
  bit wr_bits[$];
  initial begin
    ref_read_clk_out = 1'b0;
    sector_out = 1'b0;
    read_data_out = 1'b0;
    rd_len = 0;
    rd_idx = 0;
  end
  always begin
    #62 ref_read_clk_out = 1'b1;
    #63 ref_read_clk_out = 1'b0;
  end
  // Launch on the falling edge so bits are steady at the rising one
  always @(negedge ref_read_clk_out) begin
    if (write_gate_in) wr_bits.push_back(write_data_in);
    if (read_gate_in && rd_idx < rd_len) begin
      read_data_out <= rd_vec[rd_len - 1 - rd_idx];
      rd_idx <= rd_idx + 1;
    end else begin
      // No data to give: keep toggling so a stale bit is never mistaken for data
      read_data_out <= ~read_data_out;
    end
  end
  task load(input [95:0] v, input integer n);
    rd_vec = v;
    rd_len = n;
    rd_idx = 0;
  endtask
  task send_sector;
    @(negedge ref_read_clk_out);
    sector_out = 1'b1;
    #250 sector_out = 1'b0;
  endtask
endmodule // pfa_drive_model

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  reg clock_in, resetn_in, write_start_in, read_start_in, use_lock_in;
  reg [31:0] post_data_in;
  wire sector_in, ref_read_clk_in, read_data_in, write_gate_out, read_gate_out;
  wire write_clk_out, write_data_out, busy_out, done_out, check_ok_out, check_err_out;
  wire pattern_miss_out, maker_pattern_out;
  wire [31:0] post_data_out;
  integer err_total, num_checks;
  pfa_formatter pfa_formatter_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .write_start_in(write_start_in), .read_start_in(read_start_in),
    .post_data_in(post_data_in), .use_lock_in(use_lock_in), .sector_in(sector_in),
    .ref_read_clk_in(ref_read_clk_in), .read_data_in(read_data_in),
    .write_gate_out(write_gate_out), .read_gate_out(read_gate_out),
    .write_clk_out(write_clk_out), .write_data_out(write_data_out), .busy_out(busy_out),
    .done_out(done_out), .post_data_out(post_data_out), .check_ok_out(check_ok_out),
    .check_err_out(check_err_out), .pattern_miss_out(pattern_miss_out),
    .maker_pattern_out(maker_pattern_out));
  pfa_drive_model pfa_drive_model_inst (.read_gate_in(read_gate_out),
    .write_gate_in(write_gate_out), .write_data_in(write_data_out),
    .ref_read_clk_out(ref_read_clk_in), .sector_out(sector_in), .read_data_out(read_data_in));
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task check(input [95:0] seen, input [95:0] want);
    num_checks = num_checks + 1;
    if (seen !== want) begin
      err_total = err_total + 1;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  function [15:0] crc_of(input [31:0] d);
    integer i;
    crc_of = 16'hFFFF;
    for (i = 31; i >= 0; i = i - 1)
      crc_of = {crc_of[14:0], 1'b0} ^ ((crc_of[15] ^ d[i]) ? 16'h1021 : 16'h0000);
  endfunction
  task run_op(input rd);
    integer n;
    @(posedge clock_in);
    #1 write_start_in = !rd;
    read_start_in = rd;
    @(posedge clock_in);
    #1 write_start_in = 1'b0;
    read_start_in = 1'b0;
    check(busy_out, 1'b1);
    pfa_drive_model_inst.send_sector();
    n = 0;
    while (done_out !== 1'b1 && n < 20000) begin
      @(posedge clock_in);
      #1 n = n + 1;
    end
    if (n == 20000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  endtask
  task t_write(input lock, input [31:0] d);
    integer i, z, lo;
    reg [79:0] got;
    bit q[$];
    pfa_drive_model_inst.wr_bits.delete();
    use_lock_in = lock;
    post_data_in = d;
    run_op(1'b0);
    q = pfa_drive_model_inst.wr_bits;
    z = 0;
    while (z < q.size() && q[z] == 1'b0) z = z + 1;
    lo = lock ? 48 : 16;
    check(z + 2 >= lo && z < lo + 4, 1'b1);
    for (i = 0; i < 80; i = i + 1) got = {got[78:0], z + i < q.size() ? q[z + i] : 1'bx};
    check(got, {16'hA1FE, d, crc_of(d), 16'h0000});
  endtask
  task t_read(input [15:0] pat, input [31:0] d, input bad);
    reg [34:0] w;
    pfa_drive_model_inst.load({16'h0000, pat, d, crc_of(d) ^ {15'h0000, bad}}, 80);
    run_op(1'b1);
    w = {d, !bad, bad, pat == 16'h4E1B};
    check({post_data_out, check_ok_out, check_err_out, maker_pattern_out}, w);
  endtask
  task t_miss;
    pfa_drive_model_inst.load(96'h0, 0);
    run_op(1'b1);
    check({pattern_miss_out, check_ok_out, check_err_out}, 3'h4);
  endtask
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    resetn_in = 1'b0;
    write_start_in = 1'b0;
    read_start_in = 1'b0;
    use_lock_in = 1'b0;
    post_data_in = 32'h00000000;
    err_total = 0;
    num_checks = 0;
    repeat (10) @(posedge clock_in);
    #1 resetn_in = 1'b1;
    check({busy_out, write_gate_out, read_gate_out, done_out}, 4'h0);
    repeat (3) @(posedge clock_in);
    t_write(1'b0, 32'h12345678);
    t_write(1'b1, 32'hF00F0001);
    t_read(16'hA1FE, 32'hCAFE0042, 1'b0);
    t_read(16'h4E1B, 32'h0000FFFF, 1'b1);
    t_miss;
    wrap_up;
  end
endmodule // tb
